// File: rtl/adr_debug_regs.sv
// analog debug control registers, their static controls and the small
// logic that acts on them: output clamps, mono duplication, retune pulse
// assumes a single 40 MHz clock and a master that never overlaps strobes
module adr_debug_regs #(
    parameter int SAMPLE_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    output adr_pkg::adr_one_t hp_ctrl,
    output adr_pkg::adr_two_t conv_ctrl,
    output logic pll_osc_retune_pulse,
    input wire logic hp_powered,
    input wire logic center_powered,
    output adr_pkg::adr_clamp_t clamp,
    input wire logic [SAMPLE_W-1:0] dac_left_in,
    input wire logic [SAMPLE_W-1:0] dac_right_in,
    output logic [SAMPLE_W-1:0] dac_left_out,
    output logic [SAMPLE_W-1:0] dac_right_out
);

    adr_pkg::adr_one_t next_hp_ctrl;
    adr_pkg::adr_two_t next_conv_ctrl;
    logic [15:0] next_rd_data;
    logic next_pll_osc_retune_pulse;
    adr_pkg::adr_clamp_t next_clamp;
    logic [SAMPLE_W-1:0] next_dac_left_out;
    logic [SAMPLE_W-1:0] next_dac_right_out;

    // write word seen through the field layouts, read only by the checks below
    adr_pkg::adr_one_t wr_one;
    adr_pkg::adr_two_t wr_two;
    assign wr_one = wr_data;
    assign wr_two = wr_data;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    // register file
    always_comb begin
        next_hp_ctrl = hp_ctrl;
        next_conv_ctrl = conv_ctrl;
        if (wr_en && hit(addr, adr_pkg::ADR_ONE_OFFSET)) begin
            next_hp_ctrl = adr_pkg::adr_one_t'(wr_data); // RULE_01
        end
        if (wr_en && hit(addr, adr_pkg::ADR_TWO_OFFSET)) begin
            // top bit held at zero, writes to it dropped
            next_conv_ctrl = adr_pkg::adr_two_t'(wr_data & adr_pkg::ADR_TWO_WR_MASK); // RULE_22
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hp_ctrl <= adr_pkg::adr_one_t'(adr_pkg::ADR_ONE_RESET); // RULE_04
            conv_ctrl <= adr_pkg::adr_two_t'(adr_pkg::ADR_TWO_RESET); // RULE_20
        end else begin
            hp_ctrl <= next_hp_ctrl;
            conv_ctrl <= next_conv_ctrl;
        end
    end

    // read port: data valid only in the cycle after the strobe
    always_comb begin
        next_rd_data = adr_pkg::ADR_READ_IDLE;
        if (rd_en && hit(addr, adr_pkg::ADR_ONE_OFFSET)) begin
            next_rd_data = hp_ctrl;
        end else if (rd_en && hit(addr, adr_pkg::ADR_TWO_OFFSET)) begin
            next_rd_data = conv_ctrl & adr_pkg::ADR_TWO_WR_MASK; // RULE_22
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= adr_pkg::ADR_READ_IDLE;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // retune fires on the falling write only; a held level does nothing
    always_comb begin
        next_pll_osc_retune_pulse = conv_ctrl.pll_osc_retune && !next_conv_ctrl.pll_osc_retune; // RULE_12
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pll_osc_retune_pulse <= 1'b0;
        end else begin
            pll_osc_retune_pulse <= next_pll_osc_retune_pulse;
        end
    end

    // clamps follow the power state with one cycle of lag
    always_comb begin
        next_clamp.hp_gnd_tie = hp_ctrl.hp_ground_clamp && !hp_powered; // RULE_06
        next_clamp.center_gnd_tie = hp_ctrl.hp_center_ground_clamp && !center_powered; // RULE_05
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clamp <= '0;
        end else begin
            clamp <= next_clamp;
        end
    end

    // dac sample path, one register stage; right copies left in mono mode
    always_comb begin
        next_dac_left_out = dac_left_in;
        next_dac_right_out = conv_ctrl.dac_left_dup ? dac_left_in : dac_right_in; // RULE_11
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dac_left_out <= '0;
            dac_right_out <= '0;
        end else begin
            dac_left_out <= next_dac_left_out;
            dac_right_out <= next_dac_right_out;
        end
    end

    // the remaining fields leave on hp_ctrl and conv_ctrl as static levels:
    // RULE_02 RULE_03 RULE_07 RULE_08 RULE_09 RULE_10
    // RULE_13 RULE_14 RULE_15 RULE_16 RULE_17 RULE_18 RULE_19

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    one_write_store_a: assert property ( // RULE_01
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=> hp_ctrl == $past(wr_data)
    ) else $error("first debug register did not store written word");

    two_top_zero_a: assert property ( // RULE_22
        conv_ctrl.reserved_top == 1'b0
    ) else $error("second debug register top bit not zero");

    two_write_store_a: assert property ( // RULE_20
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl == ($past(wr_data) & adr_pkg::ADR_TWO_WR_MASK)
    ) else $error("second debug register did not store written word");

    regs_hold_a: assert property ( // RULE_04
        !wr_en |=> $stable(hp_ctrl) && $stable(conv_ctrl)
    ) else $error("debug registers changed without a write");

    read_one_a: assert property ( // RULE_09
        rd_en && addr == adr_pkg::ADR_ONE_OFFSET && !wr_en |=> rd_data == $past(hp_ctrl)
    ) else $error("read of first register returned wrong data");

    read_idle_a: assert property ( // RULE_22
        !rd_en |=> rd_data == adr_pkg::ADR_READ_IDLE
    ) else $error("read data not zero outside the read answer");

    retune_fall_a: assert property ( // RULE_12
        conv_ctrl.pll_osc_retune ##1 !conv_ctrl.pll_osc_retune |-> pll_osc_retune_pulse
    ) else $error("retune pulse missing after high then low");

    retune_static_a: assert property ( // RULE_12
        $stable(conv_ctrl.pll_osc_retune) [*2] |-> !pll_osc_retune_pulse
    ) else $error("retune pulse without a falling write");

    hp_clamp_a: assert property ( // RULE_06
        hp_ctrl.hp_ground_clamp && !hp_powered |=> clamp.hp_gnd_tie
    ) else $error("headphone not clamped while powered off");

    center_clamp_a: assert property ( // RULE_05
        !center_powered && hp_ctrl.hp_center_ground_clamp |=> clamp.center_gnd_tie
    ) else $error("center not clamped while powered off");

    mono_dup_a: assert property ( // RULE_11
        conv_ctrl.dac_left_dup |=> dac_right_out == $past(dac_left_in)
    ) else $error("right channel not fed from left in mono mode");

    mono_off_a: assert property ( // RULE_11
        !conv_ctrl.dac_left_dup |=>
            dac_right_out == $past(dac_right_in)
    ) else $error("right channel not its own input");

    left_pass_a: assert property ( // RULE_11
        1'b1 |=>
            dac_left_out == $past(dac_left_in)
    ) else $error("left channel not passed on");

    hp_clamp_off_a: assert property ( // RULE_06
        !hp_ctrl.hp_ground_clamp || hp_powered |=>
            !clamp.hp_gnd_tie
    ) else $error("headphone clamped while not asked");

    center_clamp_off_a: assert property ( // RULE_05
        !hp_ctrl.hp_center_ground_clamp || center_powered |=>
            !clamp.center_gnd_tie
    ) else $error("center clamped while not asked");

    read_two_a: assert property ( // RULE_20
        rd_en && !wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            rd_data == $past(conv_ctrl)
    ) else $error("read of second register returned wrong data");

    unmapped_write_a: assert property ( // RULE_22
        wr_en && addr != adr_pkg::ADR_ONE_OFFSET && addr != adr_pkg::ADR_TWO_OFFSET |=>
            $stable(hp_ctrl) && $stable(conv_ctrl)
    ) else $error("unmapped write changed a register");

    // reset values, checked through reset itself
    one_reset_a: assert property (@(posedge clk) disable iff (1'b0) // RULE_04
        !rst_b |=>
            hp_ctrl == adr_pkg::ADR_ONE_RESET
    ) else $error("first register reset value wrong");

    two_reset_a: assert property (@(posedge clk) disable iff (1'b0) // RULE_20
        !rst_b |=>
            conv_ctrl == adr_pkg::ADR_TWO_RESET
    ) else $error("second register reset value wrong");

    out_reset_a: assert property (@(posedge clk) disable iff (1'b0) // RULE_12
        !rst_b |=>
            rd_data == adr_pkg::ADR_READ_IDLE && !pll_osc_retune_pulse && clamp == '0
    ) else $error("side outputs not idle after reset");

    // each field lands where the analog side expects it
    total_bias_wr_a: assert property ( // RULE_01
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.hp_total_bias_trim == $past(wr_one.hp_total_bias_trim)
    ) else $error("total bias trim not stored");

    first_bias_wr_a: assert property ( // RULE_02
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.hp_first_stage_bias_trim == $past(wr_one.hp_first_stage_bias_trim)
    ) else $error("first stage bias trim not stored");

    pop_wr_a: assert property ( // RULE_03
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.hp_pop_current_ctrl == $past(wr_one.hp_pop_current_ctrl)
    ) else $error("pop current bus not stored");

    class_wr_a: assert property ( // RULE_04
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.hp_ab_class_sel == $past(wr_one.hp_ab_class_sel)
    ) else $error("class select not stored");

    center_bit_wr_a: assert property ( // RULE_05
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.hp_center_ground_clamp == $past(wr_one.hp_center_ground_clamp)
    ) else $error("center clamp bit not stored");

    hp_bit_wr_a: assert property ( // RULE_06
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.hp_ground_clamp == $past(wr_one.hp_ground_clamp)
    ) else $error("headphone clamp bit not stored");

    ref_double_wr_a: assert property ( // RULE_07
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.ref_buf_current_double == $past(wr_one.ref_buf_current_double)
    ) else $error("reference double bit not stored");

    ref_a_only_wr_a: assert property ( // RULE_07
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.ref_buf_a_only == $past(wr_one.ref_buf_a_only)
    ) else $error("reference class bit not stored");

    mux_phones_wr_a: assert property ( // RULE_08
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.test_adc_mux_to_phones == $past(wr_one.test_adc_mux_to_phones)
    ) else $error("mux to phones bit not stored");

    common_wr_a: assert property ( // RULE_09
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.test_phone_common_to_mux == $past(wr_one.test_phone_common_to_mux)
    ) else $error("phone common bit not stored");

    mic_loop_wr_a: assert property ( // RULE_09
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.test_mic_loop_path == $past(wr_one.test_mic_loop_path)
    ) else $error("mic loop bit not stored");

    test_en_wr_a: assert property ( // RULE_09
        wr_en && addr == adr_pkg::ADR_ONE_OFFSET |=>
            hp_ctrl.analog_test_path_en == $past(wr_one.analog_test_path_en)
    ) else $error("test path bit not stored");

    supply_wr_a: assert property ( // RULE_10
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.line_amp_supply_sel == $past(wr_two.line_amp_supply_sel)
    ) else $error("line supply bit not stored");

    spare_wr_a: assert property ( // RULE_20
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.spare_to_analog == $past(wr_two.spare_to_analog)
    ) else $error("spare bit not stored");

    dup_wr_a: assert property ( // RULE_11
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.dac_left_dup == $past(wr_two.dac_left_dup)
    ) else $error("mono bit not stored");

    retune_wr_a: assert property ( // RULE_12
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.pll_osc_retune == $past(wr_two.pll_osc_retune)
    ) else $error("retune bit not stored");

    line_ref_wr_a: assert property ( // RULE_13
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.line_ref_tie == $past(wr_two.line_ref_tie)
    ) else $error("reference tie bit not stored");

    dac_sample_wr_a: assert property ( // RULE_14
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.dac_sample_edge_inv == $past(wr_two.dac_sample_edge_inv)
    ) else $error("dac sample edge bit not stored");

    dac_handoff_wr_a: assert property ( // RULE_14
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.dac_handoff_edge_inv == $past(wr_two.dac_handoff_edge_inv)
    ) else $error("dac handoff edge bit not stored");

    rz_stretch_wr_a: assert property ( // RULE_16
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.dac_rz_stretch == $past(wr_two.dac_rz_stretch)
    ) else $error("rz stretch bit not stored");

    dac_double_wr_a: assert property ( // RULE_17
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.dac_double_current == $past(wr_two.dac_double_current)
    ) else $error("dac double bit not stored");

    rz_off_wr_a: assert property ( // RULE_16
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.dac_rz_off == $past(wr_two.dac_rz_off)
    ) else $error("rz off bit not stored");

    dac_class_wr_a: assert property ( // RULE_17
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.dac_amp_a_only == $past(wr_two.dac_amp_a_only)
    ) else $error("dac class bit not stored");

    adc_sample_wr_a: assert property ( // RULE_15
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.adc_sample_edge_inv == $past(wr_two.adc_sample_edge_inv)
    ) else $error("adc sample edge bit not stored");

    adc_handoff_wr_a: assert property ( // RULE_15
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.adc_handoff_edge_inv == $past(wr_two.adc_handoff_edge_inv)
    ) else $error("adc handoff edge bit not stored");

    adc_bias_wr_a: assert property ( // RULE_18
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.adc_bias_reduce == $past(wr_two.adc_bias_reduce)
    ) else $error("adc bias bit not stored");

    dither_wr_a: assert property ( // RULE_19
        wr_en && addr == adr_pkg::ADR_TWO_OFFSET |=>
            conv_ctrl.dither_off_a == $past(wr_two.dither_off_a)
    ) else $error("dither bit not stored");

    cover_retune_c: cover property (
        conv_ctrl.pll_osc_retune ##[1:20] pll_osc_retune_pulse
    );
    cover_mono_c: cover property (
        conv_ctrl.dac_left_dup && dac_left_in != dac_right_in
    );
    cover_class_a_c: cover property (
        !hp_ctrl.hp_ab_class_sel ##1 rd_en
    );
    cover_clamp_c: cover property (
        clamp.hp_gnd_tie ##1 !clamp.hp_gnd_tie
    );

endmodule : adr_debug_regs

// File: rtl/adr_pkg.sv
// constants and field layouts for the analog debug control register pair
// assumes a 16-bit register port whose offsets match the codec control map
// What this block does
// RULE_01: top two bits of first register trim total headphone bias, four codes
// RULE_02: next two bits trim headphone first-stage bias, four codes
// RULE_03: three-bit headphone class A current and power-off pull-down bus, resets zero
// RULE_04: headphone class select resets to one, meaning class AB; zero means class A
// RULE_05: center clamp resets one, grounds center output while center is unpowered
// RULE_06: headphone clamp resets one, grounds headphone output while driver is unpowered
// RULE_07: one bit doubles reference buffer class A current; another drops class AB current
// RULE_08: test bit routes ADC input mux onto headphone pin; remove the load
// RULE_09: low three bits enable test paths, mic loop, phone common in mux
// RULE_10: second register bit fourteen moves line amp supply to analog rail
// RULE_11: mono duplication bit feeds left DAC sample to both channels
// RULE_12: retune bit written high then low triggers one oscillator recalibration
// RULE_13: bit ten ties main analog reference to line output reference
// RULE_14: two bits invert DAC sampling edge and DAC data handoff edge
// RULE_15: two bits invert ADC sampling edge and ADC data handoff edge
// RULE_16: bit seven stretches DAC return-to-zero; bit five turns it off
// RULE_17: bit four forces DAC amp to class A; bit six doubles its current
// RULE_18: ADC bias reduction bit lowers ADC bias currents by one fifth
// RULE_19: lowest bit of second register turns ADC dither off
// RULE_20: bit thirteen is a read-write spare to analog, resets zero
// RULE_21: software keeps both registers at reset values outside debugging
// RULE_22: top bit of second register reads zero and ignores writes
package adr_pkg;

    localparam logic [15:0] ADR_ONE_OFFSET = 16'h0038;
    localparam logic [15:0] ADR_TWO_OFFSET = 16'h003a;
    localparam logic [15:0] ADR_ONE_RESET = 16'h01c0;
    localparam logic [15:0] ADR_TWO_RESET = 16'h0000;
    localparam logic [15:0] ADR_TWO_WR_MASK = 16'h7fff;
    localparam logic [15:0] ADR_READ_IDLE = 16'h0000;

    typedef enum logic [1:0] {
        ADR_TOTAL_NOMINAL = 2'h0,
        ADR_TOTAL_MINUS_50 = 2'h1,
        ADR_TOTAL_PLUS_50 = 2'h2,
        ADR_TOTAL_MINUS_40 = 2'h3
    } adr_total_bias_t;

    typedef enum logic [1:0] {
        ADR_FIRST_NOMINAL = 2'h0,
        ADR_FIRST_MINUS_50 = 2'h1,
        ADR_FIRST_PLUS_100 = 2'h2,
        ADR_FIRST_PLUS_50 = 2'h3
    } adr_first_bias_t;

    // layout follows the register bit order, msb first
    typedef struct packed {
        adr_total_bias_t hp_total_bias_trim;
        adr_first_bias_t hp_first_stage_bias_trim;
        logic [2:0] hp_pop_current_ctrl;
        logic hp_ab_class_sel;
        logic hp_center_ground_clamp;
        logic hp_ground_clamp;
        logic ref_buf_current_double;
        logic ref_buf_a_only;
        logic test_adc_mux_to_phones;
        logic test_phone_common_to_mux;
        logic test_mic_loop_path;
        logic analog_test_path_en;
    } adr_one_t;

    typedef struct packed {
        logic reserved_top;
        logic line_amp_supply_sel;
        logic spare_to_analog;
        logic dac_left_dup;
        logic pll_osc_retune;
        logic line_ref_tie;
        logic dac_sample_edge_inv;
        logic dac_handoff_edge_inv;
        logic dac_rz_stretch;
        logic dac_double_current;
        logic dac_rz_off;
        logic dac_amp_a_only;
        logic adc_sample_edge_inv;
        logic adc_handoff_edge_inv;
        logic adc_bias_reduce;
        logic dither_off_a;
    } adr_two_t;

    typedef struct packed {
        logic hp_gnd_tie;
        logic center_gnd_tie;
    } adr_clamp_t;

endpackage : adr_pkg

// File: testbench/tb_top.sv
// self-checking bench for the analog debug register pair and its side logic
// assumes the register port is driven here directly, one strobe per cycle
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wr_data = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic hp_powered = 1'b1;
    logic center_powered = 1'b1;
    logic [15:0] dl = 16'h0000;
    logic [15:0] dr = 16'h0000;
    logic [15:0] rd_data;
    adr_pkg::adr_one_t hp_ctrl;
    adr_pkg::adr_two_t conv_ctrl;
    adr_pkg::adr_clamp_t clamp;
    logic pulse;
    logic [15:0] lo;
    logic [15:0] ro;
    logic [15:0] m1, m2, mrd, mlo, mro;
    logic [1:0] mcl;
    logic mp;
    logic live = 1'b0;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    adr_debug_regs #(.SAMPLE_W(16)) DUT (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .hp_ctrl(hp_ctrl), .conv_ctrl(conv_ctrl), .pll_osc_retune_pulse(pulse),
        .hp_powered(hp_powered), .center_powered(center_powered), .clamp(clamp),
        .dac_left_in(dl), .dac_right_in(dr), .dac_left_out(lo), .dac_right_out(ro));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // one bus cycle; call right after a rising edge
    task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
        wr_en <= w;
        rd_en <= r;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
    endtask : bus
    // reference model, old register values used before they are updated
    always @(posedge clk) begin
        live = 1'b1;
        if (!rst_b) begin
            m1 = 16'h01c0; m2 = 16'h0000; mrd = 16'h0000; mlo = 16'h0000; mro = 16'h0000;
            mcl = 2'b00; mp = 1'b0;
        end else begin
            mp = wr_en && addr == 16'h003a && m2[11] && !wr_data[11];
            mcl = {m1[6] & ~hp_powered, m1[7] & ~center_powered};
            mlo = dl;
            mro = m2[12] ? dl : dr;
            mrd = !rd_en ? 16'h0000 : addr == 16'h0038 ? m1 : addr == 16'h003a ? m2 : 16'h0000;
            if (wr_en && addr == 16'h0038) m1 = wr_data;
            if (wr_en && addr == 16'h003a) m2 = wr_data & 16'h7fff;
        end
    end
    always @(negedge clk) begin
        if (live) begin
            chk(hp_ctrl, m1);
            chk(conv_ctrl, m2);
            chk(rd_data, mrd);
            chk({14'h0000, clamp}, {14'h0000, mcl});
            chk({15'h0000, pulse}, {15'h0000, mp});
            chk(lo, mlo);
            chk(ro, mro);
        end
    end
    // random samples and power levels every cycle
    always @(posedge clk) begin
        dl <= 16'($urandom);
        dr <= 16'($urandom);
        hp_powered <= 1'($urandom);
        center_powered <= 1'($urandom);
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(8376));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, 1, 16'h0038, 16'h0000);
        bus(0, 1, 16'h003a, 16'h0000);
        bus(0, 0, 16'h0000, 16'h0000);
        $display("test reset values done");
        // every bias code, written and read back to back
        for (int i = 0; i < 4; i++) begin
            bus(1, 0, 16'h0038, {2'(i), 2'(3 - i), 12'($urandom)});
            bus(0, 1, 16'h0038, 16'h0000);
        end
        $display("test field codes done");
        // falls only on 1 to 0; repeated 0 or 1 gives nothing
        bus(1, 0, 16'h003a, 16'h0800);
        bus(1, 0, 16'h003a, 16'h0000);
        bus(1, 0, 16'h003a, 16'h0000);
        bus(1, 0, 16'h003a, 16'h0800);
        bus(1, 0, 16'h003a, 16'h0800);
        bus(1, 0, 16'h003a, 16'hf7ff);
        bus(0, 0, 16'h0000, 16'h0000);
        $display("test retune done");
        bus(1, 0, 16'h003a, 16'hffff);
        bus(0, 1, 16'h003a, 16'h0000);
        bus(1, 0, 16'h003c, 16'h1234);
        bus(0, 1, 16'h003c, 16'h0000);
        bus(0, 1, 16'h0036, 16'h0000);
        $display("test reserved and unmapped done");
        // random traffic over both registers and a neighbour address
        for (int i = 0; i < 300; i++) begin
            bus(1'($urandom), 1'b0, 16'h0038 + 16'(2 * ($urandom % 3)), 16'($urandom));
            bus(1'b0, 1'($urandom), 16'h0038 + 16'(2 * ($urandom % 3)), 16'h0000);
        end
        $display("test random traffic done");
        rst_b <= 1'b0;
        bus(0, 0, 16'h0000, 16'h0000);
        rst_b <= 1'b1;
        bus(0, 1, 16'h0038, 16'h0000);
        bus(0, 1, 16'h003a, 16'h0000);
        bus(0, 0, 16'h0000, 16'h0000);
        @(posedge clk);
        $display("test second reset done");
        finish_test();
    end
endmodule : tb_top
